/* File: design/nsqc_pkg.sv */
// nsqc_pkg: shared constants and types of the nap/sleep quiesce controller.
// assumes: 32-bit apb register slave, one processor clock at 40 MHz.
package nsqc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned    APB_AW          = 8;
  localparam logic [7:0]     OFS_HW_CONFIG   = 8'h00;
  localparam logic [7:0]     OFS_POWER_SAVE  = 8'h04;
  localparam logic [7:0]     OFS_L2_CONTROL  = 8'h08;
  localparam logic [7:0]     OFS_STATUS      = 8'h0C;

  // power-saving mode bits of hw_config_reg0, plus trigger and l2 enable bit positions
  localparam int unsigned    DOZE_POS        = 8;
  localparam int unsigned    NAP_POS         = 9;
  localparam int unsigned    SLEEP_POS       = 10;
  localparam int unsigned    TRIGGER_POS     = 0;
  localparam int unsigned    L2_ENABLE_POS   = 0;
  localparam logic [2:0]     MODE_RESET      = 3'h0;

  // status register layout
  localparam int unsigned    ST_STATE_LSB    = 0;
  localparam int unsigned    ST_QUIESCE_REQ_N_POS     = 4;
  localparam int unsigned    ST_PLL_POS      = 5;
  localparam int unsigned    ST_DLL_POS      = 6;
  localparam int unsigned    ST_L2RDY_POS    = 7;
  localparam int unsigned    ST_ACKNEG_POS   = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0]     SNOOP_NEG_CYCLES = 4'h4;
  localparam logic [3:0]     NEG_SAT          = 4'h8;
  localparam int unsigned    ENTER_CYCLES     = 4;
  localparam int unsigned    RESUME_CYCLES    = 3;
  localparam int unsigned    DLL_RELOCK_CYCLES = 640;
  localparam int unsigned    L2_CLK_COUNT     = 5;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NSQC_FULL   = 4'h0,
    NSQC_REQ    = 4'h1,
    NSQC_ENTER  = 4'h3,
    NSQC_NAP    = 4'h2,
    NSQC_SNOOP  = 4'h6,
    NSQC_PUSH   = 4'h7,
    NSQC_RESUME = 4'h5,
    NSQC_SLEEP  = 4'h4,
    NSQC_DOZE   = 4'hC
  } nsqc_state_t;

endpackage

/* File: design/nsqc_pin_sync.sv */
// nsqc_pin_sync: two-flop synchroniser for a group of pin inputs.
// assumes: bits are independent levels; ce_i low freezes both stages.
`timescale 1ns/10ps
module nsqc_pin_sync #(
  parameter int unsigned    W         = 1,
  parameter logic [W-1:0]   RESET_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = ce_i ? d_i : meta;
    next_q    = ce_i ? meta : q_o;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule

/* File: design/nsqc_ctrl.sv */
// nsqc_ctrl: nap, doze and sleep entry/exit; nap and sleep use the quiesce handshake.
// assumes: apb master on clk_i, pins synchronised here, l2 clock = clk_i.
//
// Function
// - ack negated four cycles: nap becomes snooping doze
// - ack back, no push: nap resumes shortly
// - push needed: stay awake until data done
// - wake causes return nap to full power
// - sleep stops units, snooping and time base
// - sleep disables receivers and clock regenerators
// - pll stops when bypassed with reference stopped
// - kill mode stops the pll regardless
// - running pll keeps dll and l2 clocks
// - all state retained while clock frozen
// - request, wait for ack, then sleep
// - sleep needs sleep bit alone plus trigger
// - l2 ready only after 640 relock cycles
// - bus operations complete before nap or sleep
// - single mode bit plus trigger selects mode
// - nap needs nap bit alone plus trigger
// - doze snoop hit enables caches for push
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module nsqc_ctrl
  import nsqc_pkg::*;
#(
  parameter int unsigned ENTER_CNT  = ENTER_CYCLES,
  parameter int unsigned RESUME_CNT = RESUME_CYCLES,
  parameter int unsigned RELOCK_CNT = DLL_RELOCK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              quiesce_ack_n_i,
  input  wire logic              addr_tenure_start_n_i,
  input  wire logic              ext_irq_n_i,
  input  wire logic              sys_mgmt_irq_n_i,
  input  wire logic              machine_check_n_i,
  input  wire logic              soft_reset_n_i,
  input  wire logic              pll_cfg_bypass_i,
  input  wire logic              pll_cfg_kill_i,
  input  wire logic              ref_clock_in_active_i,
  input  wire logic              dec_irq_i,
  input  wire logic              perf_irq_i,
  input  wire logic              thermal_irq_i,
  input  wire logic              bus_idle_i,
  input  wire logic              snoop_push_i,
  input  wire logic              push_done_i,
  output logic                   quiesce_req_n_o,
  output logic                   unit_clk_en_o,
  output logic                   snoop_en_o,
  output logic                   cache_en_o,
  output logic                   timebase_en_o,
  output logic                   tau_pmon_en_o,
  output logic                   rcv_en_o,
  output logic                   clk_regen_en_o,
  output logic                   pll_run_o,
  output logic                   dll_en_o,
  output logic [L2_CLK_COUNT-1:0] l2_clk_en_o,
  output logic                   l2_ready_o,
  output logic [3:0]             mode_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_n_s;
  logic [2:0] pll_s;
  logic       ack_n_s;
  logic       ts_n_s;
  logic       irq_pin;

  nsqc_pin_sync #(.W(6), .RESET_VAL(6'h3F)) u_sync_n (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       ({quiesce_ack_n_i, addr_tenure_start_n_i, ext_irq_n_i,
                 sys_mgmt_irq_n_i, machine_check_n_i, soft_reset_n_i}),
    .q_o       (pins_n_s)
  );

  nsqc_pin_sync #(.W(3), .RESET_VAL(3'h0)) u_sync_pll (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       ({pll_cfg_bypass_i, pll_cfg_kill_i, ref_clock_in_active_i}),
    .q_o       (pll_s)
  );

  assign ack_n_s = pins_n_s[5];
  assign ts_n_s  = pins_n_s[4];
  assign irq_pin = ~&pins_n_s[3:0];

  // ----------------------------------------------------------------
  // registers and apb slave
  // ----------------------------------------------------------------
  localparam logic [3:0] ENTER_LAST  = 4'(ENTER_CNT - 1);
  localparam logic [3:0] RESUME_LAST = 4'(RESUME_CNT - 1);
  localparam logic [9:0] RELOCK_LAST = 10'(RELOCK_CNT - 1);

  nsqc_state_t state, next_state;
  logic [2:0]  mode_bits, next_mode_bits;
  logic        trigger, next_trigger;
  logic        l2_enable_bit, next_l2_enable_bit;
  logic [31:0] next_prdata;
  logic [3:0]  neg_cnt, next_neg_cnt;
  logic [3:0]  seq_cnt, next_seq_cnt;
  logic [9:0]  relock_cnt, next_relock_cnt;
  logic        relock_done, next_relock_done;
  logic        wr;
  logic        addr_ok;
  logic        wake_nap;
  logic        wake_sleep;
  logic        mode_ok;

  function automatic logic one_hot3(input logic [2:0] v);
    one_hot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
  endfunction

  function automatic logic is_reg(input logic [APB_AW-1:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  assign addr_ok   = is_reg(paddr_i, OFS_HW_CONFIG) || is_reg(paddr_i, OFS_POWER_SAVE)
                   || is_reg(paddr_i, OFS_L2_CONTROL) || is_reg(paddr_i, OFS_STATUS);
  assign wr        = psel_i && penable_i && pwrite_i && ce_i && addr_ok;
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  always_comb begin
    next_prdata = prdata_o;
    if (psel_i && ce_i) begin
      next_prdata = 32'h0;
      if (is_reg(paddr_i, OFS_HW_CONFIG)) begin
        next_prdata[SLEEP_POS:DOZE_POS] = mode_bits;
      end
      if (is_reg(paddr_i, OFS_POWER_SAVE)) begin
        next_prdata[TRIGGER_POS] = trigger;
      end
      if (is_reg(paddr_i, OFS_L2_CONTROL)) begin
        next_prdata[L2_ENABLE_POS] = l2_enable_bit;
      end
      if (is_reg(paddr_i, OFS_STATUS)) begin
        next_prdata[ST_STATE_LSB+3:ST_STATE_LSB] = state;
        next_prdata[ST_QUIESCE_REQ_N_POS]   = ~quiesce_req_n_o;
        next_prdata[ST_PLL_POS]    = pll_run_o;
        next_prdata[ST_DLL_POS]    = dll_en_o;
        next_prdata[ST_L2RDY_POS]  = l2_ready_o;
        next_prdata[ST_ACKNEG_POS] = ack_n_s;
      end
    end
  end

  always_comb begin
    next_mode_bits     = mode_bits;
    next_l2_enable_bit = l2_enable_bit;
    next_trigger       = trigger;
    // hardware drops the trigger once a wake returns to full power
    if (ce_i && state != NSQC_FULL && next_state == NSQC_FULL) begin
      next_trigger = 1'b0;
    end
    if (wr && is_reg(paddr_i, OFS_HW_CONFIG)) begin
      next_mode_bits = pwdata_i[SLEEP_POS:DOZE_POS];
    end
    if (wr && is_reg(paddr_i, OFS_POWER_SAVE)) begin
      next_trigger = pwdata_i[TRIGGER_POS];
    end
    if (wr && is_reg(paddr_i, OFS_L2_CONTROL)) begin
      next_l2_enable_bit = pwdata_i[L2_ENABLE_POS];
    end
  end

  // ----------------------------------------------------------------
  // power-state sequencer
  // ----------------------------------------------------------------
  assign mode_ok    = one_hot3(mode_bits) && trigger;
  assign wake_sleep = irq_pin || perf_irq_i || thermal_irq_i;
  assign wake_nap   = wake_sleep || dec_irq_i;

  always_comb begin
    next_neg_cnt = neg_cnt;
    if (ce_i) begin
      next_neg_cnt = !ack_n_s ? 4'h0 : (neg_cnt == NEG_SAT) ? neg_cnt : neg_cnt + 4'h1;
    end
  end

  always_comb begin
    next_state   = state;
    next_seq_cnt = seq_cnt;
    if (ce_i) begin
      next_seq_cnt = seq_cnt + 4'h1;
      case (state)
        NSQC_FULL: begin
          next_seq_cnt = 4'h0;
          if (mode_ok && mode_bits[DOZE_POS-DOZE_POS]) begin
            next_state = NSQC_DOZE;
          end else if (mode_ok) begin
            next_state = NSQC_REQ;
          end
        end
        NSQC_REQ: begin
          next_seq_cnt = 4'h0;
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (!ack_n_s && bus_idle_i) begin
            next_state = NSQC_ENTER;
          end
        end
        NSQC_ENTER: begin
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (seq_cnt == ENTER_LAST) begin
            next_state = mode_bits[SLEEP_POS-DOZE_POS] ? NSQC_SLEEP : NSQC_NAP;
          end
        end
        NSQC_NAP: begin
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (neg_cnt >= SNOOP_NEG_CYCLES) begin
            next_state = NSQC_SNOOP;
          end
        end
        NSQC_SNOOP: begin
          next_seq_cnt = 4'h0;
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (snoop_push_i) begin
            next_state = NSQC_PUSH;
          end else if (!ack_n_s && ts_n_s) begin
            next_state = NSQC_RESUME;
          end
        end
        NSQC_PUSH: begin
          next_seq_cnt = 4'h0;
          if (push_done_i) begin
            next_state = mode_bits[DOZE_POS-DOZE_POS] ? NSQC_DOZE : NSQC_RESUME;
          end
        end
        NSQC_RESUME: begin
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (neg_cnt >= SNOOP_NEG_CYCLES) begin
            next_state = NSQC_SNOOP;
          end else if (seq_cnt == RESUME_LAST) begin
            next_state = NSQC_NAP;
          end
        end
        NSQC_SLEEP: begin
          // decrementer is stopped here, so only the other causes wake
          if (wake_sleep) begin
            next_state = NSQC_FULL;
          end
        end
        NSQC_DOZE: begin
          if (wake_nap) begin
            next_state = NSQC_FULL;
          end else if (snoop_push_i) begin
            next_state = NSQC_PUSH;
          end
        end
        default: begin
          next_state = NSQC_FULL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clocks, pll and dll
  // ----------------------------------------------------------------
  assign pll_run_o   = !(pll_s[2] && !pll_s[0]) && !pll_s[1];
  assign dll_en_o    = pll_run_o && l2_enable_bit;
  assign l2_clk_en_o = {L2_CLK_COUNT{dll_en_o}};
  assign l2_ready_o  = dll_en_o && relock_done;

  always_comb begin
    next_relock_cnt  = relock_cnt;
    next_relock_done = relock_done;
    if (ce_i) begin
      if (!dll_en_o) begin
        next_relock_cnt  = 10'h000;
        next_relock_done = 1'b0;
      end else if (!relock_done) begin
        next_relock_cnt  = relock_cnt + 10'h001;
        next_relock_done = (relock_cnt == RELOCK_LAST);
      end
    end
  end

  assign quiesce_req_n_o = (state == NSQC_FULL) || (state == NSQC_DOZE);
  assign unit_clk_en_o   = (state == NSQC_FULL);
  assign snoop_en_o      = !(state == NSQC_ENTER || state == NSQC_NAP
                             || state == NSQC_SLEEP);
  assign cache_en_o      = (state == NSQC_FULL) || (state == NSQC_PUSH);
  assign timebase_en_o   = (state != NSQC_SLEEP);
  assign tau_pmon_en_o   = 1'b1;
  assign rcv_en_o        = !(state == NSQC_NAP || state == NSQC_SLEEP);
  assign clk_regen_en_o  = (state != NSQC_SLEEP);
  assign mode_o          = state;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state         <= NSQC_FULL;
      mode_bits     <= MODE_RESET;
      trigger       <= 1'b0;
      l2_enable_bit <= 1'b0;
      prdata_o      <= 32'h0;
      neg_cnt       <= 4'h0;
      seq_cnt       <= 4'h0;
      relock_cnt    <= 10'h000;
      relock_done   <= 1'b0;
    end else begin
      state         <= next_state;
      mode_bits     <= next_mode_bits;
      trigger       <= next_trigger;
      l2_enable_bit <= next_l2_enable_bit;
      prdata_o      <= next_prdata;
      neg_cnt       <= next_neg_cnt;
      seq_cnt       <= next_seq_cnt;
      relock_cnt    <= next_relock_cnt;
      relock_done   <= next_relock_done;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_dll_fresh;
    $rose(dll_en_o);
  endsequence

  property p_snoop_entry;
    state == NSQC_NAP && ce_i && !wake_nap && neg_cnt >= SNOOP_NEG_CYCLES |=> state == NSQC_SNOOP;
  endproperty
  a_snoop_entry: assert property (p_snoop_entry) else $error("nap did not open snooping");

  property p_resume_nap;
    state == NSQC_RESUME && seq_cnt == RESUME_LAST && ce_i && !wake_nap && neg_cnt == 4'h0
      |=> state == NSQC_NAP;
  endproperty
  a_resume_nap: assert property (p_resume_nap) else $error("nap not resumed");

  property p_push_hold;
    state == NSQC_PUSH && !push_done_i |=> state == NSQC_PUSH && cache_en_o;
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("left push early");

  property p_nap_wake;
    state == NSQC_NAP && ce_i && wake_nap |=> state == NSQC_FULL ##0 quiesce_req_n_o;
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("nap wake missed");

  property p_sleep_off;
    state == NSQC_SLEEP |-> !snoop_en_o && !timebase_en_o && !unit_clk_en_o && tau_pmon_en_o;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("unit active in sleep");

  property p_sleep_rcv;
    state == NSQC_SLEEP |-> !rcv_en_o && !clk_regen_en_o;
  endproperty
  a_sleep_rcv: assert property (p_sleep_rcv) else $error("receivers on in sleep");

  // judged from the pins two enabled cycles back, not from the synchroniser copy
  property p_pll_stop;
    $past(ce_i) && $past(ce_i, 2) && $past(reset_n_i) && $past(reset_n_i, 2)
      |-> pll_run_o == !(($past(pll_cfg_bypass_i, 2) && !$past(ref_clock_in_active_i, 2))
                         || $past(pll_cfg_kill_i, 2));
  endproperty
  a_pll_stop: assert property (p_pll_stop) else $error("pll run wrong");

  property p_l2_clocks;
    pll_run_o && l2_enable_bit |-> l2_clk_en_o == {L2_CLK_COUNT{1'b1}} && dll_en_o;
  endproperty
  a_l2_clocks: assert property (p_l2_clocks) else $error("l2 clocks stopped");

  property p_relock_wait;
    s_dll_fresh |-> !l2_ready_o [*8];
  endproperty
  a_relock_wait: assert property (p_relock_wait) else $error("l2 ready too early");

  property p_enter_needs_ack;
    state == NSQC_REQ && ce_i && (ack_n_s || !bus_idle_i) |=> state != NSQC_ENTER;
  endproperty
  a_enter_needs_ack: assert property (p_enter_needs_ack) else $error("entered without ack");

  property p_mode_gate;
    state == NSQC_FULL && !mode_ok |=> state == NSQC_FULL;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("bad mode left full power");

  property p_req_full;
    state == NSQC_FULL |-> quiesce_req_n_o;
  endproperty
  a_req_full: assert property (p_req_full) else $error("request held at full power");

endmodule

/* File: verif/nsqc_sys_model.sv */
// nsqc_sys_model: system bus logic on the far side of the quiesce handshake.
// assumes: same clock as the controller; snoop_cmd_i is a one-cycle pulse.
`timescale 1ns/10ps
module nsqc_sys_model #(
  parameter int unsigned ACK_DLY  = 2,
  parameter int unsigned NEG_LEN  = 10,
  parameter int unsigned PUSH_LEN = 8
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic quiesce_req_n_i,
  input  wire logic snoop_cmd_i,
  input  wire logic push_cmd_i,
  output logic      quiesce_ack_n_o,
  output logic      addr_tenure_start_n_o,
  output logic      snoop_push_o,
  output logic      push_done_o
);
  // --------------
  // sequencer
  // --------------
  int unsigned cnt;
  int          ph;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ph <= 0;
      cnt <= 0;
      quiesce_ack_n_o <= 1'h1;
      addr_tenure_start_n_o <= 1'h1;
      snoop_push_o <= 1'h0;
      push_done_o <= 1'h0;
    end else begin
      case (ph)
        0: begin
          if (snoop_cmd_i) begin // negate ack before presenting a snoop
            ph <= 1;
            cnt <= 0;
            quiesce_ack_n_o <= 1'h1;
          end else if (quiesce_req_n_i) begin
            cnt <= 0;
            quiesce_ack_n_o <= 1'h1;
          end else if (cnt >= ACK_DLY) begin // ack once snooping unneeded
            quiesce_ack_n_o <= 1'h0;
          end else begin
            cnt <= cnt + 1;
          end
        end
        1: begin // longer than four cycles, covers bursts
          cnt <= cnt + 1;
          if (cnt == NEG_LEN - 1) begin
            ph <= 2;
            addr_tenure_start_n_o <= 1'h0;
            snoop_push_o <= push_cmd_i;
          end
        end
        2: begin // ack back one cycle after tenure start
          addr_tenure_start_n_o <= 1'h1;
          quiesce_ack_n_o <= 1'h0;
          cnt <= snoop_push_o ? 0 : ACK_DLY;
          ph <= snoop_push_o ? 3 : 0;
        end
        default: begin // push data tenure, then its end
          cnt <= cnt + 1;
          push_done_o <= (cnt == PUSH_LEN);
          if (cnt == PUSH_LEN) snoop_push_o <= 1'h0;
          if (push_done_o) ph <= 0;
        end
      endcase
    end
  end
endmodule

/* File: verif/testbench.sv */
// testbench: drives the quiesce controller over apb and its wake pins.
// assumes: nsqc_sys_model answers the handshake; relock count cut to 16.
`timescale 1ns/10ps
module testbench
  import nsqc_pkg::*;
;
  // --------------
  // signals
  // --------------
  logic        clk_i = 0, reset_n_i = 0, ce_i = 1;
  logic        psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
  logic [7:0]  paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic        quiesce_ack_n_i, addr_tenure_start_n_i, snoop_push_i, push_done_i;
  logic        pll_cfg_bypass_i = 0, pll_cfg_kill_i = 0, ref_clock_in_active_i = 1;
  logic        bus_idle_i = 1, snoop_cmd = 0, push_cmd = 0, er;
  logic [6:0]  wk = '0;
  logic        quiesce_req_n_o, unit_clk_en_o, snoop_en_o, cache_en_o, timebase_en_o;
  logic        tau_pmon_en_o, rcv_en_o, clk_regen_en_o, pll_run_o, dll_en_o, l2_ready_o;
  logic [4:0]  l2_clk_en_o;
  logic [3:0]  mode_o;
  wire         ext_irq_n_i = !wk[0], sys_mgmt_irq_n_i = !wk[1], machine_check_n_i = !wk[2];
  wire         dec_irq_i = wk[3], perf_irq_i = wk[4], thermal_irq_i = wk[5];
  wire         soft_reset_n_i = !wk[6];
  wire [9:0]   outs = {quiesce_req_n_o, unit_clk_en_o, snoop_en_o, cache_en_o, timebase_en_o,
                       tau_pmon_en_o, rcv_en_o, clk_regen_en_o, pll_run_o, dll_en_o};
  int          errors = 0, check_count = 0;
  logic [7:0]  ofs[4] = '{OFS_HW_CONFIG, OFS_POWER_SAVE, OFS_L2_CONTROL, OFS_STATUS};
  logic [31:0] rv[4] = '{32'h0, 32'h0, 32'h0, 32'h120};
  logic [3:0]  pt[4] = '{4'h8, 4'h1, 4'h6, 4'hB};

  nsqc_ctrl #(.RELOCK_CNT(16)) uut (.*);
  nsqc_sys_model sys (.clk_i, .reset_n_i, .quiesce_req_n_i(quiesce_req_n_o),
    .snoop_cmd_i(snoop_cmd), .push_cmd_i(push_cmd), .quiesce_ack_n_o(quiesce_ack_n_i),
    .addr_tenure_start_n_o(addr_tenure_start_n_i), .snoop_push_o(snoop_push_i),
    .push_done_o(push_done_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------
  // tasks
  // --------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // no fixed latency assumed: wait for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    chk("pready", 32'h1, 32'(pready_o));
    if (pready_o !== 1'h1) wrap_up();
  endtask

  task automatic mode_is(input logic [3:0] m, input int lim);
    int n;
    n = 0;
    while (mode_o !== m && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("mode", 32'(m), 32'(mode_o));
    if (mode_o !== m) wrap_up();
  endtask

  // --------------
  // sequence
  // --------------
  initial begin
    cyc(16);
    reset_n_i <= 1'h1;
    cyc(4);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, ofs[i], 32'h0);
      chk("reg", rv[i], rd);
      chk("slverr", 32'h0, 32'(er));
    end
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("outs", 32'h3FE, 32'(outs));
    $display("test reset done");
    apb(1'h1, OFS_HW_CONFIG, 32'h200);
    bus_idle_i <= 1'h0;
    apb(1'h1, OFS_POWER_SAVE, 32'h1);
    cyc(12);
    mode_is(NSQC_REQ, 0);
    chk("quiesce_req_n_n", 32'h0, 32'(quiesce_req_n_o));
    bus_idle_i <= 1'h1;
    mode_is(NSQC_NAP, 40);
    chk("outs", 32'h036, 32'(outs));
    snoop_cmd <= 1'h1;
    cyc(1);
    snoop_cmd <= 1'h0;
    mode_is(NSQC_SNOOP, 20);
    chk("outs", 32'h0BE, 32'(outs));
    mode_is(NSQC_NAP, 30);
    push_cmd <= 1'h1;
    snoop_cmd <= 1'h1;
    cyc(1);
    snoop_cmd <= 1'h0;
    mode_is(NSQC_PUSH, 30);
    chk("outs", 32'h0FE, 32'(outs));
    cyc(3);
    mode_is(NSQC_PUSH, 0);
    push_cmd <= 1'h0;
    mode_is(NSQC_NAP, 30);
    $display("test nap and snoop done");
    // soft reset goes last in case it also clears the mode bits
    for (int i = 0; i < 7; i++) begin
      wk <= 7'(1 << i);
      mode_is(NSQC_FULL, 10);
      chk("outs", 32'h3FE, 32'(outs));
      wk <= '0;
      cyc(4);
      if (i < 6) begin
        apb(1'h1, OFS_POWER_SAVE, 32'h1);
        mode_is(NSQC_NAP, 40);
      end
    end
    $display("test wake done");
    apb(1'h1, OFS_HW_CONFIG, 32'h300);
    apb(1'h1, OFS_POWER_SAVE, 32'h1);
    cyc(8);
    mode_is(NSQC_FULL, 0);
    apb(1'h1, OFS_POWER_SAVE, 32'h0);
    apb(1'h1, OFS_HW_CONFIG, 32'h100);
    apb(1'h1, OFS_POWER_SAVE, 32'h1);
    mode_is(NSQC_DOZE, 4);
    chk("outs", 32'h2BE, 32'(outs));
    wk <= 7'h10;
    mode_is(NSQC_FULL, 10);
    wk <= '0;
    $display("test mode select done");
    apb(1'h1, OFS_L2_CONTROL, 32'h1);
    cyc(1);
    chk("l2clk", 32'h1F, 32'(l2_clk_en_o));
    chk("l2rdy", 32'h0, 32'(l2_ready_o));
    cyc(15);
    chk("l2rdy", 32'h0, 32'(l2_ready_o));
    cyc(1);
    chk("l2rdy", 32'h1, 32'(l2_ready_o));
    $display("test l2 relock done");
    apb(1'h1, OFS_HW_CONFIG, 32'h400);
    apb(1'h1, OFS_POWER_SAVE, 32'h1);
    mode_is(NSQC_SLEEP, 40);
    chk("outs", 32'h013, 32'(outs));
    wk <= 7'h08;
    cyc(6);
    mode_is(NSQC_SLEEP, 0);
    wk <= 7'h02; // a wake pin pulse while frozen must be lost
    ce_i <= 1'h0;
    cyc(8);
    wk <= '0;
    ce_i <= 1'h1;
    apb(1'h0, OFS_L2_CONTROL, 32'h0);
    chk("l2ctl", 32'h1, rd);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("status", 32'hF4, rd);
    mode_is(NSQC_SLEEP, 0);
    for (int i = 0; i < 4; i++) begin
      {pll_cfg_bypass_i, pll_cfg_kill_i, ref_clock_in_active_i} <= pt[i][3:1];
      cyc(4);
      chk("pll", 32'(pt[i][0]), 32'(pll_run_o));
      chk("dll", 32'(pt[i][0]), 32'(dll_en_o));
    end
    pll_cfg_bypass_i <= 1'h0; // reference already running
    cyc(4);
    wk <= 7'h02; // wake before the 16-cycle relock has finished
    mode_is(NSQC_FULL, 10);
    chk("quiesce_req_n_n", 32'h1, 32'(quiesce_req_n_o));
    wk <= '0;
    $display("test sleep done");
    wrap_up();
  end
endmodule
